// ===== can_rx_pkg.sv
package can_rx_pkg;

	// ********************************************************
	// register byte addresses
	// ********************************************************
	localparam logic [11:0] MCR_OFS   = 12'h000;
	localparam logic [11:0] RFS_OFS   = 12'h004;
	localparam logic [11:0] IER_OFS   = 12'h008;
	localparam logic [11:0] FCR_OFS   = 12'h00C;
	localparam logic [11:0] FMR_OFS   = 12'h010;
	localparam logic [11:0] TCNT_OFS  = 12'h014;
	localparam logic [11:0] TCAP_OFS  = 12'h018;
	localparam logic [11:0] MBOX_OFS  = 12'h020;
	localparam logic [11:0] FBANK_OFS = 12'h040;

	// ********************************************************
	// field positions
	// ********************************************************
	localparam int MCR_LOCK_BIT = 0;
	localparam int MCR_TT_BIT   = 1;
	localparam int RFS_CNT_LSB  = 0;
	localparam int RFS_FULL_BIT = 3;
	localparam int RFS_OVR_BIT  = 4;
	localparam int RFS_REL_BIT  = 5;
	localparam int IER_PEND_BIT = 1;
	localparam int IER_FULL_BIT = 2;
	localparam int IER_OVR_BIT  = 3;
	localparam int FCR_ACT_BIT  = 0;
	localparam int FCR_SC_LSB   = 1;
	localparam int FCR_FIELD_W  = 4;
	localparam int FMR_HIGH_LSB = 8;

	// ********************************************************
	// reset values and sizes
	// ********************************************************
	localparam logic [1:0]  MCR_RST   = 2'h0;
	localparam logic [2:0]  IER_RST   = 3'h0;
	localparam logic [31:0] FCR_RST   = 32'h0000_0000;
	localparam logic [15:0] FMR_RST   = 16'h0000;
	localparam logic [7:0]  FBYTE_RST = 8'h00;
	localparam logic [15:0] TS_RST    = 16'h0000;
	localparam logic [1:0]  FIFO_DEPTH = 2'h3;

	typedef enum logic [1:0] {
		SC_8X4  = 2'h0,
		SC_16_8 = 2'h1,
		SC_16X2 = 2'h2,
		SC_32   = 2'h3
	} filter_scale_t;

	typedef struct packed {
		logic [10:0] standard_identifier;
		logic        ide;
		logic [17:0] extended_identifier;
		logic        rtr;
		logic [3:0]  dlc;
		logic [63:0] data;
	} rx_frame_t;

	typedef struct packed {
		logic [5:0]  filter_match_index;
		logic [3:0]  dlc;
		logic [31:0] id;
		logic [63:0] data;
		logic [15:0] ts;
	} rx_entry_t;

endpackage

// ===== can_rx_fifo_filter.sv
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/100ps

// What this block does
// - time mode: counter runs, captured at SOF
// - three-entry receive FIFO, one output mailbox
// - valid needs no error and filter pass
// - first message into empty FIFO: count 01b
// - release frees entry, shows next message
// - further messages raise count to 10b, 11b
// - message while full sets overrun flag
// - unlocked overwrites newest, locked discards incoming
// - each store may raise pending interrupt
// - third store sets full; overrun may interrupt
// - eight filter banks of eight bytes
// - scale 3: one 32-bit filter
// - scale 2: two 16-bit filters
// - scale 0: four 8-bit filters, ID[10:3]
// - scale 1: 16-bit low, two 8-bit high
// - mask mode compares only must-match bits
// - list mode: exact match of stored identifiers
// - low bit rules low bytes, high bit high; scale 3 uses the low bit for both
// - matching filter index stored with message
// - priority: list, coverage, then lower number
// - list first, then mask; unmatched silently dropped
// - mailbox byte layout: index, length, id, data, stamp
module can_rx_fifo_filter #(
	parameter int ADDR_W = 12,
	parameter int BANKS  = 8
) (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic [ADDR_W-1:0]    paddr,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [31:0]          pwdata,
	input  wire logic [3:0]           pstrb,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire can_rx_pkg::rx_frame_t rx_frame,
	input  wire logic                 rx_frame_end,
	input  wire logic                 rx_frame_err,
	input  wire logic                 sof_sample,
	output logic                      pending_irq,
	output logic                      full_irq,
	output logic                      overrun_irq
);

	// ********************************************************
	// helpers
	// ********************************************************
	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic fmatch(input logic [31:0] inc, input logic [31:0] idv, input logic [31:0] msk,
		input logic list);
		if (list) begin
			return inc == idv;
		end
		return ((inc ^ idv) & msk) == 32'h0000_0000;
	endfunction

	function automatic logic [1:0] add3(input logic [1:0] a, input logic [1:0] b);
		logic [2:0] s;
		s = {1'b0, a} + {1'b0, b};
		if (s >= {1'b0, can_rx_pkg::FIFO_DEPTH}) begin
			s = s - {1'b0, can_rx_pkg::FIFO_DEPTH};
		end
		return s[1:0];
	endfunction

	// ********************************************************
	// state
	// ********************************************************
	logic [1:0]  mcr_r, mcr_nxt;
	logic [2:0]  ier_r, ier_nxt;
	logic [31:0] fcr_r, fcr_nxt;
	logic [15:0] fmr_r, fmr_nxt;
	logic [7:0]  bank_r   [0:BANKS-1][0:7];
	logic [7:0]  bank_nxt [0:BANKS-1][0:7];
	can_rx_pkg::rx_entry_t fifo_r [0:2];
	can_rx_pkg::rx_entry_t fifo_nxt [0:2];
	logic [1:0]  rd_r, rd_nxt;
	logic [1:0]  cnt_r, cnt_nxt;
	logic        full_r, full_nxt;
	logic        ovr_r, ovr_nxt;
	logic [15:0] tcnt_r, tcnt_nxt;
	logic [15:0] time_stamp_r, time_stamp_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic        slverr_r, slverr_nxt;
	logic        pend_irq_r, full_irq_r, ovr_irq_r;

	logic        wr;
	logic        setup;
	logic [31:0] inc_id;
	logic [8*BANKS-1:0] cand_hit;
	logic [8*BANKS-1:0] cand_list;
	logic [16*BANKS-1:0] cand_cov;
	logic        accept;
	logic [5:0]  match_idx;
	logic [127:0] mbox;

	assign wr     = psel & penable & pwrite;
	assign setup  = psel & ~penable;
	assign pready = psel & penable;
	assign prdata = prdata_r;
	assign pslverr = slverr_r;
	assign pending_irq = pend_irq_r;
	assign full_irq    = full_irq_r;
	assign overrun_irq = ovr_irq_r;

	// identifier in the byte order of the filter registers
	assign inc_id = {rx_frame.standard_identifier, rx_frame.rtr, rx_frame.ide,
		rx_frame.extended_identifier, 1'b0};

	// ********************************************************
	// filter banks
	// ********************************************************
	for (genvar b = 0; b < BANKS; b++) begin : g_bank
		logic [7:0]  hit;
		logic [7:0]  lst;
		logic [15:0] cov;
		logic        ml;
		logic        mh;
		logic [1:0]  sc;
		logic [7:0]  rb [0:7];

		always_comb begin
			for (int k = 0; k < 8; k++) begin
				rb[k] = bank_r[b][k];
			end
			ml  = fmr_r[b];
			mh  = fmr_r[can_rx_pkg::FMR_HIGH_LSB + b];
			sc  = fcr_r[b*can_rx_pkg::FCR_FIELD_W + can_rx_pkg::FCR_SC_LSB +: 2];
			hit = 8'h00;
			lst = 8'h00;
			cov = 16'h0000;
			if (fcr_r[b*can_rx_pkg::FCR_FIELD_W + can_rx_pkg::FCR_ACT_BIT]) begin
				if (sc == can_rx_pkg::SC_32) begin
					// both halves take the low mode bit; software keeps them equal
					hit[0] = fmatch(inc_id, {rb[0], rb[1], rb[2], rb[3]}, {rb[4], rb[5], rb[6], rb[7]}, ml);
					hit[4] = ml && (inc_id == {rb[4], rb[5], rb[6], rb[7]});
					lst[0] = ml;
					lst[4] = ml;
					cov[1:0] = 2'h3;
					cov[9:8] = 2'h3;
				end
				if (sc == can_rx_pkg::SC_16X2 || sc == can_rx_pkg::SC_16_8) begin
					hit[0] = fmatch({inc_id[31:16], 16'h0000}, {rb[0], rb[1], 16'h0000},
						{rb[2], rb[3], 16'h0000}, ml);
					hit[2] = ml && (inc_id[31:16] == {rb[2], rb[3]});
					lst[0] = ml;
					lst[2] = ml;
					cov[1:0] = 2'h2;
					cov[5:4] = 2'h2;
				end
				if (sc == can_rx_pkg::SC_16X2) begin
					hit[4] = fmatch({inc_id[31:16], 16'h0000}, {rb[4], rb[5], 16'h0000},
						{rb[6], rb[7], 16'h0000}, mh);
					hit[6] = mh && (inc_id[31:16] == {rb[6], rb[7]});
					lst[4] = mh;
					lst[6] = mh;
					cov[9:8]   = 2'h2;
					cov[13:12] = 2'h2;
				end
				for (int k = 0; k < 8; k++) begin
					if ((k < 4 && sc == can_rx_pkg::SC_8X4) ||
						(k >= 4 && (sc == can_rx_pkg::SC_8X4 || sc == can_rx_pkg::SC_16_8))) begin
						if ((k < 4) ? ml : mh) begin
							hit[k] = inc_id[31:24] == rb[k];
							lst[k] = 1'b1;
							cov[2*k +: 2] = 2'h1;
						end else if (k % 2 == 0) begin
							hit[k] = ((inc_id[31:24] ^ rb[k]) & rb[k+1]) == 8'h00;
							cov[2*k +: 2] = 2'h1;
						end
					end
				end
			end
		end

		assign cand_hit[8*b +: 8]   = hit;
		assign cand_list[8*b +: 8]  = lst;
		assign cand_cov[16*b +: 16] = cov;
	end

	// ********************************************************
	// match index resolution
	// ********************************************************
	always_comb begin
		logic [9:0] best;
		logic [9:0] key;
		best = 10'h000;
		key  = 10'h000;
		for (int i = 0; i < 8*BANKS; i++) begin
			if (cand_hit[i]) begin
				// list first, then coverage, then lowest number
				key = {1'b1, cand_list[i], cand_cov[2*i +: 2], ~i[5:0]};
				if (key > best) begin
					best = key;
				end
			end
		end
		accept    = best[9];
		match_idx = ~best[5:0];
	end

	// ********************************************************
	// output mailbox image
	// ********************************************************
	always_comb begin
		can_rx_pkg::rx_entry_t e;
		e = fifo_r[rd_r];
		if (cnt_r == 2'h0) begin
			mbox = 128'h0;
		end else begin
			mbox = {e.ts[15:8], e.ts[7:0], e.data,
				e.id[7:0], e.id[15:8], e.id[23:16], e.id[31:24],
				{4'h0, e.dlc}, {2'h0, e.filter_match_index}};
		end
	end

	// ********************************************************
	// configuration registers
	// ********************************************************
	always_comb begin
		mcr_nxt = mcr_r;
		ier_nxt = ier_r;
		fcr_nxt = fcr_r;
		fmr_nxt = fmr_r;
		bank_nxt = bank_r;
		if (wr) begin
			if (paddr == can_rx_pkg::MCR_OFS) begin
				mcr_nxt = pstrb[0] ? pwdata[1:0] : mcr_r;
			end
			if (paddr == can_rx_pkg::IER_OFS) begin
				ier_nxt = pstrb[0] ? pwdata[3:1] : ier_r;
			end
			if (paddr == can_rx_pkg::FCR_OFS) begin
				fcr_nxt = wmerge(fcr_r, pwdata, pstrb);
			end
			if (paddr == can_rx_pkg::FMR_OFS) begin
				fmr_nxt = 16'(wmerge({16'h0000, fmr_r}, pwdata, pstrb));
			end
			if (paddr[ADDR_W-1:6] == can_rx_pkg::FBANK_OFS[ADDR_W-1:6]) begin
				for (int k = 0; k < 4; k++) begin
					if (pstrb[k]) begin
						bank_nxt[paddr[5:3]][{paddr[2], 2'(k)}] = pwdata[8*k +: 8];
					end
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mcr_r <= can_rx_pkg::MCR_RST;
			ier_r <= can_rx_pkg::IER_RST;
			fcr_r <= can_rx_pkg::FCR_RST;
			fmr_r <= can_rx_pkg::FMR_RST;
			for (int b = 0; b < BANKS; b++) begin
				for (int k = 0; k < 8; k++) begin
					bank_r[b][k] <= can_rx_pkg::FBYTE_RST;
				end
			end
		end else begin
			mcr_r <= mcr_nxt;
			ier_r <= ier_nxt;
			fcr_r <= fcr_nxt;
			fmr_r <= fmr_nxt;
			bank_r <= bank_nxt;
		end
	end

	// ********************************************************
	// time stamp counter
	// ********************************************************
	always_comb begin
		tcnt_nxt = mcr_r[can_rx_pkg::MCR_TT_BIT] ? tcnt_r + 16'h0001 : can_rx_pkg::TS_RST;
		time_stamp_nxt = time_stamp_r;
		if (mcr_r[can_rx_pkg::MCR_TT_BIT] && sof_sample) begin
			time_stamp_nxt = tcnt_r;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tcnt_r       <= can_rx_pkg::TS_RST;
			time_stamp_r <= can_rx_pkg::TS_RST;
		end else begin
			tcnt_r       <= tcnt_nxt;
			time_stamp_r <= time_stamp_nxt;
		end
	end

	// ********************************************************
	// receive fifo
	// ********************************************************
	always_comb begin
		logic rel;
		logic store;
		can_rx_pkg::rx_entry_t ne;
		rel   = wr && paddr == can_rx_pkg::RFS_OFS && pstrb[0] && pwdata[can_rx_pkg::RFS_REL_BIT];
		store = rx_frame_end && !rx_frame_err && accept;
		ne.filter_match_index = match_idx;
		ne.dlc  = rx_frame.dlc;
		ne.id   = inc_id;
		ne.data = rx_frame.data;
		ne.ts   = time_stamp_r;
		fifo_nxt = fifo_r;
		rd_nxt   = rd_r;
		cnt_nxt  = cnt_r;
		full_nxt = full_r;
		ovr_nxt  = ovr_r;
		if (wr && paddr == can_rx_pkg::RFS_OFS && pstrb[0]) begin
			full_nxt = full_r & ~pwdata[can_rx_pkg::RFS_FULL_BIT];
			ovr_nxt  = ovr_r & ~pwdata[can_rx_pkg::RFS_OVR_BIT];
		end
		if (rel && cnt_r != 2'h0) begin
			rd_nxt  = add3(rd_r, 2'h1);
			cnt_nxt = cnt_r - 2'h1;
		end
		if (store) begin
			if (cnt_nxt != can_rx_pkg::FIFO_DEPTH) begin
				fifo_nxt[add3(rd_nxt, cnt_nxt)] = ne;
				cnt_nxt = cnt_nxt + 2'h1;
				if (cnt_nxt == can_rx_pkg::FIFO_DEPTH) begin
					full_nxt = 1'b1;
				end
			end else begin
				ovr_nxt = 1'b1;
				if (!mcr_r[can_rx_pkg::MCR_LOCK_BIT]) begin
					fifo_nxt[add3(rd_nxt, 2'h2)] = ne;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 3; i++) begin
				fifo_r[i] <= '0;
			end
			rd_r       <= 2'h0;
			cnt_r      <= 2'h0;
			full_r     <= 1'b0;
			ovr_r      <= 1'b0;
			pend_irq_r <= 1'b0;
			full_irq_r <= 1'b0;
			ovr_irq_r  <= 1'b0;
		end else begin
			fifo_r     <= fifo_nxt;
			rd_r       <= rd_nxt;
			cnt_r      <= cnt_nxt;
			full_r     <= full_nxt;
			ovr_r      <= ovr_nxt;
			pend_irq_r <= ier_r[0] && cnt_nxt != 2'h0;
			full_irq_r <= ier_r[1] && full_nxt;
			ovr_irq_r  <= ier_r[2] && ovr_nxt;
		end
	end

	// ********************************************************
	// apb read path
	// ********************************************************
	always_comb begin
		prdata_nxt = prdata_r;
		slverr_nxt = slverr_r;
		if (setup) begin
			prdata_nxt = 32'h0000_0000;
			slverr_nxt = 1'b0;
			if (paddr == can_rx_pkg::MCR_OFS) begin
				prdata_nxt = {30'h0, mcr_r};
			end else if (paddr == can_rx_pkg::RFS_OFS) begin
				// release bit always reads zero
				prdata_nxt = {27'h0, ovr_r, full_r, 1'b0, cnt_r};
			end else if (paddr == can_rx_pkg::IER_OFS) begin
				prdata_nxt = {28'h0, ier_r, 1'b0};
			end else if (paddr == can_rx_pkg::FCR_OFS) begin
				prdata_nxt = fcr_r;
			end else if (paddr == can_rx_pkg::FMR_OFS) begin
				prdata_nxt = {16'h0000, fmr_r};
			end else if (paddr == can_rx_pkg::TCNT_OFS) begin
				prdata_nxt = {16'h0000, tcnt_r};
			end else if (paddr == can_rx_pkg::TCAP_OFS) begin
				prdata_nxt = {16'h0000, time_stamp_r};
			end else if (paddr[ADDR_W-1:4] == can_rx_pkg::MBOX_OFS[ADDR_W-1:4]) begin
				prdata_nxt = mbox[32*paddr[3:2] +: 32];
			end else if (paddr[ADDR_W-1:6] == can_rx_pkg::FBANK_OFS[ADDR_W-1:6]) begin
				prdata_nxt = {bank_r[paddr[5:3]][{paddr[2], 2'h3}], bank_r[paddr[5:3]][{paddr[2], 2'h2}],
					bank_r[paddr[5:3]][{paddr[2], 2'h1}], bank_r[paddr[5:3]][{paddr[2], 2'h0}]};
			end else begin
				slverr_nxt = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0000_0000;
			slverr_r <= 1'b0;
		end else begin
			prdata_r <= prdata_nxt;
			slverr_r <= slverr_nxt;
		end
	end

endmodule

// ===== can_rx_fifo_filter_monitor.sv
`timescale 1ns/100ps
// ****************
// port checker
// ****************
module can_rx_fifo_filter_monitor #(
	parameter int ADDR_W = 12,
	parameter int BANKS  = 8
) (
	input wire logic                  pclk,
	input wire logic                  presetn,
	input wire logic [ADDR_W-1:0]     paddr,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [31:0]           pwdata,
	input wire logic [3:0]            pstrb,
	input wire logic [31:0]           prdata,
	input wire logic                  pready,
	input wire logic                  pslverr,
	input wire can_rx_pkg::rx_frame_t rx_frame,
	input wire logic                  rx_frame_end,
	input wire logic                  rx_frame_err,
	input wire logic                  sof_sample,
	input wire logic                  pending_irq,
	input wire logic                  full_irq,
	input wire logic                  overrun_irq
);
	localparam logic [ADDR_W-1:0] BAD_ADDR = 12'hFFC;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_bad_frame;
		rx_frame_end && rx_frame_err && !(psel && penable && pwrite);
	endsequence
	property p_zero_wait; psel && penable |-> pready; endproperty
	a_zero_wait: assert property (p_zero_wait) else $error("access without ready");
	property p_unmapped; s_setup ##0 (paddr == BAD_ADDR) |=> pslverr; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access not flagged");
	property p_mapped; s_setup ##0 (paddr == can_rx_pkg::MCR_OFS) |=> !pslverr; endproperty
	a_mapped: assert property (p_mapped) else $error("mapped access flagged");
	property p_rel_zero; s_setup ##0 (!pwrite && paddr == can_rx_pkg::RFS_OFS) |=> !prdata[5]; endproperty
	a_rel_zero: assert property (p_rel_zero) else $error("release bit reads one");
	property p_pend_rise; $rose(pending_irq) |-> $past(rx_frame_end) || $past(psel && penable && pwrite); endproperty
	a_pend_rise: assert property (p_pend_rise) else $error("pending irq without cause");
	property p_full_rise; $rose(full_irq) |-> $past(rx_frame_end) || $past(psel && penable && pwrite); endproperty
	a_full_rise: assert property (p_full_rise) else $error("full irq without cause");
	property p_ovr_rise; $rose(overrun_irq) |-> $past(rx_frame_end) || $past(psel && penable && pwrite); endproperty
	a_ovr_rise: assert property (p_ovr_rise) else $error("overrun irq without cause");
	property p_err_quiet; s_bad_frame |=> $stable({pending_irq, full_irq, overrun_irq}); endproperty
	a_err_quiet: assert property (p_err_quiet) else $error("bad frame changed irqs");
	property p_pend_fall; $fell(pending_irq) |-> $past(psel && penable && pwrite); endproperty
	a_pend_fall: assert property (p_pend_fall) else $error("pending irq fell alone");
endmodule

// ===== can_core_model.sv
`timescale 1ns/100ps
// ****************
// protocol core stand-in
// ****************
module can_core_model (
	input  wire logic             pclk,
	output can_rx_pkg::rx_frame_t rx_frame,
	output logic                  rx_frame_end,
	output logic                  rx_frame_err,
	output logic                  sof_sample
);
	initial begin
		rx_frame = '0;
		rx_frame_end = 1'b0;
		rx_frame_err = 1'b0;
		sof_sample = 1'b0;
	end
	task automatic send(input logic [10:0] std, input logic err);
		can_rx_pkg::rx_frame_t f;
		f = '0;
		f.standard_identifier = std;
		f.dlc = 4'h8;
		f.data = 64'h5A;
		sof_sample <= 1'b1;
		@(posedge pclk);
		sof_sample <= 1'b0;
		rx_frame <= f;
		rx_frame_end <= 1'b1;
		rx_frame_err <= err;
		@(posedge pclk);
		rx_frame_end <= 1'b0;
		rx_frame_err <= 1'b0;
		// released lines show a changed pattern
		rx_frame <= ~f;
		@(posedge pclk);
	endtask
endmodule

// ===== tb_can_rx_fifo_filter.sv
`timescale 1ns/100ps
// ****************
// bench
// ****************
module tb_can_rx_fifo_filter;
	logic                  pclk;
	logic                  presetn;
	logic [11:0]           paddr;
	logic                  psel;
	logic                  penable;
	logic                  pwrite;
	logic [31:0]           pwdata;
	logic [3:0]            pstrb;
	logic [31:0]           prdata;
	logic                  pready;
	logic                  pslverr;
	can_rx_pkg::rx_frame_t rx_frame;
	logic                  rx_frame_end;
	logic                  rx_frame_err;
	logic                  sof_sample;
	logic                  pending_irq;
	logic                  full_irq;
	logic                  overrun_irq;
	logic [31:0]           rd;
	logic                  err_seen;
	int                    bad_count = 0;
	int                    n_tests = 0;
	int                    cyc = 0;

	can_rx_fifo_filter #(.ADDR_W(12), .BANKS(8)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rx_frame(rx_frame), .rx_frame_end(rx_frame_end),
		.rx_frame_err(rx_frame_err), .sof_sample(sof_sample), .pending_irq(pending_irq),
		.full_irq(full_irq), .overrun_irq(overrun_irq));
	can_core_model core (.pclk(pclk), .rx_frame(rx_frame), .rx_frame_end(rx_frame_end),
		.rx_frame_err(rx_frame_err), .sof_sample(sof_sample));

	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			give_verdict();
		end
	end

	// ****************
	// helpers
	// ****************
	task give_verdict;
		if (bad_count == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// pready ends this wait; without it only the bench timeout does
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd = prdata;
		err_seen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	function automatic logic [31:0] idw(input logic [10:0] s);
		return {16'h0000, s[2:0], 5'h00, s[10:3]};
	endfunction
	task chk_st(input logic [1:0] cnt, input logic full, input logic ovr);
		apb(1'b0, can_rx_pkg::RFS_OFS, 32'h0);
		chk("fifo status", {26'h0, 1'b0, ovr, full, 1'b0, cnt}, rd);
	endtask
	task chk_msg(input logic [10:0] s, input logic [5:0] idx);
		logic [31:0] i;
		i = idw(s);
		apb(1'b0, can_rx_pkg::MBOX_OFS, 32'h0);
		chk("mailbox word0", {i[15:0], 8'h08, 2'b00, idx}, rd);
		apb(1'b0, can_rx_pkg::MBOX_OFS + 12'h004, 32'h0);
		chk("mailbox word1", {16'h005A, i[31:16]}, rd);
		apb(1'b1, can_rx_pkg::RFS_OFS, 32'h0000_0020);
	endtask

	// ****************
	// scenarios
	// ****************
	task t_fifo(input logic lock);
		apb(1'b1, can_rx_pkg::MCR_OFS, {31'h0, lock});
		for (int k = 1; k <= 4; k++) begin
			core.send(11'(k), 1'b0);
			chk_st((k > 3) ? 2'h3 : 2'(k), k >= 3, k == 4);
		end
		chk("irq levels", 32'h7, {29'h0, pending_irq, full_irq, overrun_irq});
		chk_msg(11'h001, 6'h00);
		chk_msg(11'h002, 6'h00);
		chk_msg(lock ? 11'h003 : 11'h004, 6'h00);
		chk_st(2'h0, 1'b1, 1'b1);
		apb(1'b1, can_rx_pkg::RFS_OFS, 32'h0000_0020);
		chk_st(2'h0, 1'b1, 1'b1);
		apb(1'b1, can_rx_pkg::RFS_OFS, 32'h0000_0018);
		chk_st(2'h0, 1'b0, 1'b0);
		chk("irq levels clear", 32'h0, {29'h0, pending_irq, full_irq, overrun_irq});
	endtask
	task t_err;
		core.send(11'h123, 1'b1);
		chk_st(2'h0, 1'b0, 1'b0);
		apb(1'b0, 12'hFFC, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, err_seen});
	endtask
	task t_filter;
		logic [31:0] w, x, y;
		w = idw(11'h700);
		x = idw(11'h123);
		y = idw(11'h456);
		apb(1'b1, can_rx_pkg::FCR_OFS, 32'h0);
		apb(1'b1, can_rx_pkg::FBANK_OFS, {8'hFF, w[7:0], 8'hFF, w[7:0]});
		apb(1'b1, can_rx_pkg::FBANK_OFS + 12'h004, {8'hFF, w[7:0], 8'hFF, w[7:0]});
		apb(1'b1, can_rx_pkg::FBANK_OFS + 12'h008, {y[15:0], x[15:0]});
		apb(1'b1, can_rx_pkg::FBANK_OFS + 12'h00C, {y[15:0], x[15:0]});
		apb(1'b1, can_rx_pkg::FMR_OFS, 32'h0000_0202);
		apb(1'b1, can_rx_pkg::FCR_OFS, 32'h0000_0051);
		core.send(11'h123, 1'b0);
		core.send(11'h456, 1'b0);
		core.send(11'h700, 1'b0);
		core.send(11'h0F0, 1'b0);
		chk_st(2'h3, 1'b1, 1'b0);
		chk_msg(11'h123, 6'h08);
		chk_msg(11'h456, 6'h0A);
		chk_msg(11'h700, 6'h00);
		apb(1'b1, can_rx_pkg::RFS_OFS, 32'h0000_0018);
		// bank 1 to two 16-bit list plus four 8-bit list filters
		apb(1'b1, can_rx_pkg::FCR_OFS, 32'h0000_0001);
		apb(1'b1, can_rx_pkg::FCR_OFS, 32'h0000_0031);
		core.send(11'h300, 1'b0);
		core.send(11'h456, 1'b0);
		chk_msg(11'h300, 6'h0D);
		chk_msg(11'h456, 6'h0A);
	endtask
	task t_time;
		logic [31:0] a;
		apb(1'b1, can_rx_pkg::MCR_OFS, 32'h0000_0002);
		apb(1'b0, can_rx_pkg::TCNT_OFS, 32'h0);
		a = rd;
		apb(1'b0, can_rx_pkg::TCNT_OFS, 32'h0);
		chk("time count step", 32'h3, rd - a);
		// counter latched at setup edge; start of frame sampled three edges later
		a = rd;
		core.send(11'h700, 1'b0);
		apb(1'b0, can_rx_pkg::TCAP_OFS, 32'h0);
		chk("time stamp", a + 32'h3, rd);
		apb(1'b0, can_rx_pkg::MBOX_OFS + 12'h00C, 32'h0);
		chk("mailbox stamp", {a[15:0] + 16'h0003, 16'h0000}, rd);
		apb(1'b1, can_rx_pkg::RFS_OFS, 32'h0000_0020);
		apb(1'b1, can_rx_pkg::MCR_OFS, 32'h0);
		apb(1'b0, can_rx_pkg::TCNT_OFS, 32'h0);
		chk("time count held", 32'h0, rd);
	endtask

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'hF;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b1, can_rx_pkg::FCR_OFS, 32'h0000_0007);
		apb(1'b1, can_rx_pkg::IER_OFS, 32'h0000_000E);
		t_fifo(1'b0);
		t_fifo(1'b1);
		t_err();
		t_filter();
		t_time();
		give_verdict();
	end
endmodule

bind can_rx_fifo_filter can_rx_fifo_filter_monitor #(.ADDR_W(ADDR_W), .BANKS(BANKS)) u_mon (.pclk(pclk),
	.presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
	.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_frame(rx_frame),
	.rx_frame_end(rx_frame_end), .rx_frame_err(rx_frame_err), .sof_sample(sof_sample),
	.pending_irq(pending_irq), .full_irq(full_irq), .overrun_irq(overrun_irq));
